/* File: hdl/ccr_byte_capture.sv */
// Capture control of one receiver in a daisy-chained byte cascade.
//
// Contract
// - The primary receiver, enable held high, catches the first data byte after a sync.
// - After catching its byte a receiver raises its captured flag for the next one.
// - Data and command strobes of all chained receivers fire in the same cycle.
// - The violation flag is latched and presented with the data and command timing.
// - With enable high one byte is caught and held, then bytes are ignored until a sync or a low-high enable.
// - With enable low no byte is captured.
// - The flag rises only on a non-sync byte and never on a sync.
// - A sync or a falling enable drops the captured flag within the chain fall delay.
// - A sync moves the held byte to the decoder latch, and one byte clock later to the output with its strobe.
// - A byte with a code violation still counts as captured.
// - In auto-repeat a returning enable re-arms the receiver and the cycle repeats.
`timescale 1ns/1ps
module ccr_byte_capture
  import ccr_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic CAPTURE_ENABLE_IN_I,
  output logic CAPTURED_FLAG_OUT_O,
  input wire logic [1:0] DATA_WIDTH_SELECT_I,
  input wire logic SYM_VALID_I,
  input wire logic SYM_SYNC_I,
  input wire logic SYM_IS_CMD_I,
  input wire logic SYM_VIOLATION_I,
  input wire logic [ccr_pkg::DATA_W-1:0] SYM_DATA_I,
  input wire logic [ccr_pkg::CMD_W-1:0] SYM_CMD_I,
  output logic [ccr_pkg::DATA_W-1:0] DATA_OUT_O,
  output logic [ccr_pkg::CMD_W-1:0] COMMAND_OUT_O,
  output logic VIOLATION_FLAG_O,
  output logic DATA_OUT_STROBE_O,
  output logic COMMAND_OUT_STROBE_O,
  output logic IRQ_O
);

  import ccr_pkg::*;

  localparam int FALL_BOUND = CHAIN_FALL_CYC;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] o);
    reg_hit = (a == o);
  endfunction

  function automatic logic [DATA_W-1:0] width_mask(input logic [1:0] sel);
    case (sel)
      DWS_8BIT: width_mask = 10'h0FF;
      DWS_9BIT: width_mask = 10'h1FF;
      default: width_mask = 10'h3FF;
    endcase
  endfunction

  // ==========================================================================
  // Byte clock divider
  // ==========================================================================
  logic [3:0] byte_cnt_reg;
  wire byte_tick = (byte_cnt_reg == BYTE_CNT_LAST);

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      byte_cnt_reg <= 4'h0;
    end else begin
      byte_cnt_reg <= byte_tick ? 4'h0 : byte_cnt_reg + 4'h1;
    end
  end

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [31:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [31:0] rdata_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;

  // ==========================================================================
  // Capture sequencing
  // ==========================================================================
  ccr_cap_e state_reg;
  ccr_cap_e state_next;
  logic cen_last_reg;
  logic low_seen_reg;
  logic flag_reg;
  logic [DATA_W-1:0] in_data_reg;
  logic [CMD_W-1:0] in_cmd_reg;
  logic in_is_cmd_reg;
  logic in_viol_reg;

  wire run = ctrl_reg[CTRL_RUN_BIT];
  wire cen_now = CAPTURE_ENABLE_IN_I;
  // A low enable only has to show between two ticks, not at one: in the
  // auto-repeat ring the inverted last flag pulses low for a few clocks
  // only, and that pulse must still end the word and re-arm the primary.
  wire cen_low_seen = ~cen_last_reg | low_seen_reg;
  wire cen_rise = cen_now & cen_low_seen;
  wire sym_sync = byte_tick & SYM_VALID_I & SYM_SYNC_I;
  wire sym_take = byte_tick & SYM_VALID_I & ~SYM_SYNC_I;
  wire held = (state_reg == CCR_HELD);
  wire can_take = (state_reg == CCR_ARMED) | (byte_tick & cen_rise);
  wire cap_go = sym_take & cen_now & run & can_take;
  wire flush_go = byte_tick & held &
    (SYM_VALID_I & SYM_SYNC_I | ~cen_now | low_seen_reg);
  wire lost = sym_take & held & cen_now & ~cen_rise;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CCR_IDLE: begin
        if (cap_go) begin
          state_next = CCR_HELD;
        end else if (byte_tick & cen_now & (cen_rise | sym_sync)) begin
          state_next = CCR_ARMED;
        end
      end
      CCR_ARMED: begin
        if (byte_tick & ~cen_now) begin
          state_next = CCR_IDLE;
        end else if (cap_go) begin
          state_next = CCR_HELD;
        end
      end
      CCR_HELD: begin
        if (byte_tick & ~cen_now) begin
          state_next = CCR_IDLE;
        end else if (cap_go) begin
          state_next = CCR_HELD;
        end else if (sym_sync | (byte_tick & cen_rise)) begin
          state_next = CCR_ARMED;
        end
      end
      default: begin
        state_next = CCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= CCR_IDLE;
      cen_last_reg <= 1'b0;
      low_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (byte_tick) begin
        cen_last_reg <= cen_now;
        low_seen_reg <= 1'b0;
      end else if (~cen_now) begin
        low_seen_reg <= 1'b1;
      end
    end
  end

  // The flag drops on the very next clock edge when the enable goes low,
  // not at a byte tick, so the low level ripples fast down a long chain.
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      flag_reg <= 1'b0;
    end else if (~cen_now | sym_sync) begin
      flag_reg <= 1'b0;
    end else if (cap_go) begin
      flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      in_data_reg <= '0;
      in_cmd_reg <= '0;
      in_is_cmd_reg <= 1'b0;
      in_viol_reg <= 1'b0;
    end else if (cap_go) begin
      in_data_reg <= SYM_DATA_I & width_mask(DATA_WIDTH_SELECT_I);
      in_cmd_reg <= SYM_CMD_I;
      in_is_cmd_reg <= SYM_IS_CMD_I;
      in_viol_reg <= SYM_VIOLATION_I;
    end
  end

  assign CAPTURED_FLAG_OUT_O = flag_reg;

  ccr_word_latch u_word_latch (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .byte_tick_i(byte_tick),
    .flush_i(flush_go),
    .in_data_i(in_data_reg),
    .in_cmd_i(in_cmd_reg),
    .in_is_cmd_i(in_is_cmd_reg),
    .in_viol_i(in_viol_reg),
    .out_data_o(DATA_OUT_O),
    .out_cmd_o(COMMAND_OUT_O),
    .out_viol_o(VIOLATION_FLAG_O),
    .data_out_strobe_o(DATA_OUT_STROBE_O),
    .command_out_strobe_o(COMMAND_OUT_STROBE_O)
  );

  // ==========================================================================
  // AHB-Lite slave
  // ==========================================================================
  // Zero wait states: read data is latched in the address phase so that it
  // stands from a flip-flop for the whole data phase.
  wire ahb_go = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire [7:0] a_addr = HADDR_I[7:0];
  wire wr_ctrl = wr_pend_reg & reg_hit(wr_addr_reg, OFS_CTRL);
  wire wr_stat = wr_pend_reg & reg_hit(wr_addr_reg, OFS_IRQ_STAT);
  wire wr_mask = wr_pend_reg & reg_hit(wr_addr_reg, OFS_IRQ_MASK);
  wire [IRQ_W-1:0] irq_events = {lost, VIOLATION_FLAG_O &
    (DATA_OUT_STROBE_O | COMMAND_OUT_STROBE_O), COMMAND_OUT_STROBE_O,
    DATA_OUT_STROBE_O};
  wire [IRQ_W-1:0] irq_w1c = wr_stat ? HWDATA_I[IRQ_W-1:0] : '0;
  wire [31:0] status_word = {28'h0000000, cen_now, flag_reg, held,
    state_reg == CCR_ARMED};
  wire [31:0] word_word = {7'h00, VIOLATION_FLAG_O, 4'h0, COMMAND_OUT_O,
    6'h00, DATA_OUT_O};
  wire [31:0] read_mux =
    reg_hit(a_addr, OFS_CTRL) ? ctrl_reg :
    reg_hit(a_addr, OFS_STATUS) ? status_word :
    reg_hit(a_addr, OFS_IRQ_STAT) ? {28'h0000000, irq_stat_reg} :
    reg_hit(a_addr, OFS_IRQ_MASK) ? {28'h0000000, irq_mask_reg} :
    reg_hit(a_addr, OFS_WORD) ? word_word : 32'h0000_0000;

  // A new event wins over a write-one-to-clear in the same cycle.
  assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_events;

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= ahb_go & HWRITE_I;
      if (ahb_go) begin
        wr_addr_reg <= a_addr;
        rdata_reg <= HWRITE_I ? 32'h0000_0000 : read_mux;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_reg <= CTRL_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_ctrl) begin
        ctrl_reg <= {31'h00000000, HWDATA_I[CTRL_RUN_BIT]};
      end
      if (wr_mask) begin
        irq_mask_reg <= HWDATA_I[IRQ_W-1:0];
      end
    end
  end

  assign HRDATA_O = rdata_reg;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign IRQ_O = |(irq_stat_reg & irq_mask_reg);

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!ARST_N_I);

  property p_primary_capture;
    cap_go |=> (state_reg == CCR_HELD) && flag_reg;
  endproperty
  a_primary_capture: assert property (p_primary_capture)
    else $error("Armed receiver did not catch the byte.");

  property p_flag_cause;
    $rose(flag_reg) |-> $past(cap_go);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("Captured flag rose without a capture.");

  property p_hold_ignores;
    held && sym_take && cen_now && !cen_rise |=> held && $stable(in_data_reg);
  endproperty
  a_hold_ignores: assert property (p_hold_ignores)
    else $error("Held byte overwritten before sync.");

  property p_low_no_capture;
    byte_tick && !cen_now |=> !flag_reg && (state_reg != CCR_HELD);
  endproperty
  a_low_no_capture: assert property (p_low_no_capture)
    else $error("Capture while enable low.");

  property p_sync_no_flag;
    sym_sync |=> !flag_reg;
  endproperty
  a_sync_no_flag: assert property (p_sync_no_flag)
    else $error("Sync left the captured flag high.");

  property p_fall_drop;
    $fell(CAPTURE_ENABLE_IN_I) |-> ##[0:FALL_BOUND] !flag_reg;
  endproperty
  a_fall_drop: assert property (p_fall_drop)
    else $error("Flag not dropped within chain fall delay.");

  property p_viol_counts;
    cap_go && SYM_VIOLATION_I |=> flag_reg && in_viol_reg;
  endproperty
  a_viol_counts: assert property (p_viol_counts)
    else $error("Violating byte not counted as captured.");

  property p_rearm;
    byte_tick && cen_rise && !held |=>
      (state_reg == CCR_ARMED) || ((state_reg == CCR_HELD) && flag_reg);
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("Returning enable did not re-arm.");

  property p_no_rearm_without_low;
    byte_tick && held && cen_now && cen_last_reg && !low_seen_reg &&
      !sym_sync |=> held;
  endproperty
  a_no_rearm_without_low: assert property (p_no_rearm_without_low)
    else $error("Re-armed without a sampled low enable.");

  // Ring wiring: the next word's first byte is taken on the same tick
  // that ends the old word.
  property p_repeat_catch;
    byte_tick && held && cen_now && low_seen_reg && sym_take && run |=>
      held && flag_reg;
  endproperty
  a_repeat_catch: assert property (p_repeat_catch)
    else $error("Re-armed receiver missed the next byte.");

endmodule

/* File: hdl/ccr_pkg.sv */
// Shared constants and types for the cascade byte capture receiver.
package ccr_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CHAIN_FALL_DELAY_NS = 20;
  // A longest time rounds down, never below one cycle.
  localparam int unsigned CHAIN_FALL_CYC =
    (CHAIN_FALL_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
    CHAIN_FALL_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned BYTE_TIME_NS = 80;
  localparam int unsigned BYTE_CYC = BYTE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [3:0] BYTE_CNT_LAST = 4'(BYTE_CYC - 1);

  // ==========================================================================
  // Widths and data width select codes
  // ==========================================================================
  localparam int unsigned DATA_W = 10;
  localparam int unsigned CMD_W = 4;
  localparam int unsigned IRQ_W = 4;
  localparam logic [1:0] DWS_8BIT = 2'h0;
  localparam logic [1:0] DWS_9BIT = 2'h1;

  // ==========================================================================
  // Register map (byte offsets) and fields
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_WORD = 8'h10;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
  localparam int unsigned IRQ_DATA_OUT_STROBE_BIT = 0;
  localparam int unsigned IRQ_COMMAND_OUT_STROBE_BIT = 1;
  localparam int unsigned IRQ_VIOL_BIT = 2;
  localparam int unsigned IRQ_LOST_BIT = 3;
  localparam int unsigned ST_ARMED_BIT = 0;
  localparam int unsigned ST_HELD_BIT = 1;
  localparam int unsigned ST_FLAG_BIT = 2;
  localparam int unsigned ST_ENABLE_BIT = 3;
  localparam int unsigned WORD_CMD_LSB = 16;
  localparam int unsigned WORD_VIOL_BIT = 24;

  typedef enum logic [1:0] {
    CCR_IDLE,
    CCR_ARMED,
    CCR_HELD
  } ccr_cap_e;

endpackage

/* File: hdl/ccr_word_latch.sv */
// Decoder and output latch stages that present one captured byte.
`timescale 1ns/1ps
module ccr_word_latch
  import ccr_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic byte_tick_i,
  input wire logic flush_i,
  input wire logic [ccr_pkg::DATA_W-1:0] in_data_i,
  input wire logic [ccr_pkg::CMD_W-1:0] in_cmd_i,
  input wire logic in_is_cmd_i,
  input wire logic in_viol_i,
  output logic [ccr_pkg::DATA_W-1:0] out_data_o,
  output logic [ccr_pkg::CMD_W-1:0] out_cmd_o,
  output logic out_viol_o,
  output logic data_out_strobe_o,
  output logic command_out_strobe_o
);

  localparam int BYTE_WAIT = BYTE_CYC;

  logic [DATA_W-1:0] dec_data_reg;
  logic [CMD_W-1:0] dec_cmd_reg;
  logic dec_is_cmd_reg;
  logic dec_viol_reg;
  logic dec_full_reg;
  logic [DATA_W-1:0] out_data_reg;
  logic [CMD_W-1:0] out_cmd_reg;
  logic out_viol_reg;
  logic data_out_strobe_reg;
  logic command_out_strobe_reg;
  wire present = byte_tick_i & dec_full_reg;

  // ==========================================================================
  // Decoder latch
  // ==========================================================================
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dec_data_reg <= '0;
      dec_cmd_reg <= '0;
      dec_is_cmd_reg <= 1'b0;
      dec_viol_reg <= 1'b0;
      dec_full_reg <= 1'b0;
    end else if (flush_i) begin
      dec_data_reg <= in_data_i;
      dec_cmd_reg <= in_cmd_i;
      dec_is_cmd_reg <= in_is_cmd_i;
      dec_viol_reg <= in_viol_i;
      dec_full_reg <= 1'b1;
    end else if (present) begin
      dec_full_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Output latch and strobes
  // ==========================================================================
  // Every chained receiver sees the same sync on the same tick, so the
  // strobes line up across the chain with no extra handshake.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_data_reg <= '0;
      out_cmd_reg <= '0;
      out_viol_reg <= 1'b0;
      data_out_strobe_reg <= 1'b0;
      command_out_strobe_reg <= 1'b0;
    end else begin
      data_out_strobe_reg <= present & ~dec_is_cmd_reg;
      command_out_strobe_reg <= present & dec_is_cmd_reg;
      if (present) begin
        out_data_reg <= dec_data_reg;
        out_cmd_reg <= dec_cmd_reg;
        out_viol_reg <= dec_viol_reg;
      end
    end
  end

  assign out_data_o = out_data_reg;
  assign out_cmd_o = out_cmd_reg;
  assign out_viol_o = out_viol_reg;
  assign data_out_strobe_o = data_out_strobe_reg;
  assign command_out_strobe_o = command_out_strobe_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_flush;
    flush_i && byte_tick_i;
  endsequence

  property p_strobe_after_flush;
    @(posedge clk_i) disable iff (!arst_n_i)
    s_flush ##1 (!flush_i) |-> ##BYTE_WAIT (data_out_strobe_o || command_out_strobe_o);
  endproperty
  a_strobe_after_flush: assert property (p_strobe_after_flush)
    else $error("Strobe missing one byte time after word end.");

  property p_viol_with_strobe;
    @(posedge clk_i) disable iff (!arst_n_i)
    (data_out_strobe_o || command_out_strobe_o) |-> (out_viol_o == $past(dec_viol_reg));
  endproperty
  a_viol_with_strobe: assert property (p_viol_with_strobe)
    else $error("Violation flag not presented with the byte.");

  property p_strobe_on_tick;
    @(posedge clk_i) disable iff (!arst_n_i)
    (data_out_strobe_o || command_out_strobe_o) |-> $past(byte_tick_i) && !(data_out_strobe_o && command_out_strobe_o);
  endproperty
  a_strobe_on_tick: assert property (p_strobe_on_tick)
    else $error("Output strobe off the byte tick.");

endmodule

/* File: verification/ccr_byte_capture_bench.sv */
// Self-checking bench for two chained cascade byte capture receivers.
`timescale 1ns/1ps
module ccr_byte_capture_bench;
  import ccr_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] dws = 2'h2;
  logic en1 = 1'b1;
  logic ar = 1'b0;
  logic hready, f1, f2, v1, v2, ds1, cs1, ds2, cs2, irq, sv, ss, sc, svi;
  logic [31:0] hrdata, rd;
  logic [DATA_W-1:0] sd, d1o, d2o;
  logic [CMD_W-1:0] scd, c1o, c2o;
  logic [15:0] rnd = 16'h0017;
  int n_mismatch = 0;
  int comparisons = 0;
  wire s1 = ds1 | cs1;
  wire s2 = ds2 | cs2;
  wire [2:0] ev = {s1, f2, f1};
  // In ring mode the last flag, inverted, drives the primary enable.
  wire cen1 = ar ? ~f2 : en1;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  // ==========================================================================
  // Instances
  // ==========================================================================
  ccr_sym_source src (.clk_i(clk), .arst_n_i(arst_n), .valid_o(sv),
    .sync_o(ss), .is_cmd_o(sc), .viol_o(svi), .data_o(sd), .cmd_o(scd));
  // The second enable follows the first flag; the last flag feeds back, inverted,
  // to the primary enable in ring mode, and both see the same width select as the line.
  ccr_byte_capture dut (.CLOCK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(),
    .CAPTURE_ENABLE_IN_I(cen1), .CAPTURED_FLAG_OUT_O(f1),
    .DATA_WIDTH_SELECT_I(dws), .SYM_VALID_I(sv), .SYM_SYNC_I(ss),
    .SYM_IS_CMD_I(sc), .SYM_VIOLATION_I(svi), .SYM_DATA_I(sd),
    .SYM_CMD_I(scd), .DATA_OUT_O(d1o), .COMMAND_OUT_O(c1o),
    .VIOLATION_FLAG_O(v1), .DATA_OUT_STROBE_O(ds1),
    .COMMAND_OUT_STROBE_O(cs1), .IRQ_O(irq));
  ccr_byte_capture dut2 (.CLOCK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(), .HREADYOUT_O(), .HRESP_O(),
    .CAPTURE_ENABLE_IN_I(f1), .CAPTURED_FLAG_OUT_O(f2),
    .DATA_WIDTH_SELECT_I(dws), .SYM_VALID_I(sv), .SYM_SYNC_I(ss),
    .SYM_IS_CMD_I(sc), .SYM_VIOLATION_I(svi), .SYM_DATA_I(sd),
    .SYM_CMD_I(scd), .DATA_OUT_O(d2o), .COMMAND_OUT_O(c2o),
    .VIOLATION_FLAG_O(v2), .DATA_OUT_STROBE_O(ds2),
    .COMMAND_OUT_STROBE_O(cs2), .IRQ_O());

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [9:0] wmask(input logic [1:0] d);
    return (d == DWS_8BIT) ? 10'h0FF : (d == DWS_9BIT) ? 10'h1FF : 10'h3FF;
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_hi(input int b);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (ev[b] !== 1'b1 && k < 60);
    chk("event", {31'h0, ev[b]}, 32'h1);
  endtask

  // Mode 0 ends the word with a sync, mode 1 adds a byte nobody may take,
  // mode 2 ends it by dropping the primary enable while data flows,
  // mode 3 runs the auto-repeat ring for two words with no sync between.
  task automatic word(input int mode);
    logic [16:0] a, b;
    @(posedge clk);
    rnd = lfsr(rnd);
    dws <= 2'(rnd % 16'h3);
    ar <= (mode == 3);
    a = {2'b00, rnd[15], rnd[9:0], 4'h0};
    rnd = lfsr(rnd);
    b = {1'b0, rnd[0], rnd[15], rnd[13:4], rnd[3:0]};
    src.push(a);
    src.push(b);
    if (mode == 1) src.push(17'h0_0150);
    if (mode >= 2) begin
      src.push(a ^ 17'h0_3FF0);
      src.push(b ^ 17'h0_3FF0);
    end else begin
      src.push(17'h1_0000);
    end
    wait_hi(0);
    chk("flag2 early", f2, 1'b0);
    wait_hi(1);
    if (mode == 2) begin
      @(posedge clk);
      en1 <= 1'b0;
    end
    wait_hi(2);
    chk("strobe2", s2, 1'b1);
    chk("flag1", f1, mode == 3);
    chk("data1", d1o, a[13:4] & wmask(dws));
    chk("viol1", v1, a[14]);
    if (b[15]) begin
      chk("cmd2", {cs2, c2o}, {1'b1, b[3:0]});
    end else begin
      chk("data2", {ds2, v2, d2o},
        {1'b1, b[14], b[13:4] & wmask(dws)});
    end
    @(posedge clk);
    #1;
    chk("strobe pulse", {s1, s2}, 2'b00);
    if (mode == 2) begin
      repeat (20) @(posedge clk);
      en1 <= 1'b1;
      repeat (25) @(posedge clk);
    end
    if (mode == 3) begin
      wait_hi(2);
      chk("data1 repeat", d1o, ~a[13:4] & wmask(dws));
      @(posedge clk);
      ar <= 1'b0;
    end
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk("idle outputs", {f1, f2, s1, s2, irq}, 32'h0);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, CTRL_RESET);
    ahb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk("mask", rd, 32'(IRQ_MASK_RESET));
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb(1'b1, OFS_IRQ_MASK, 32'h1);
    for (int w = 0; w < 12; w++) word(w % 4);
    ahb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq status", rd & 32'h9, 32'h9);
    chk("irq", irq, 1'b1);
    ahb(1'b1, OFS_IRQ_MASK, 32'h0);
    @(posedge clk);
    #1;
    chk("irq masked", irq, 1'b0);
    ahb(1'b1, OFS_IRQ_STAT, 32'hF);
    ahb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq cleared", rd, 32'h0);
    report_and_stop();
  end

  // Twelve words need about a thousand cycles; six thousand means a hang.
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule

/* File: verification/ccr_sym_source.sv */
// Transmitter model that puts one decoded symbol on the line per byte time.
`timescale 1ns/1ps
module ccr_sym_source
  import ccr_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  output logic valid_o,
  output logic sync_o,
  output logic is_cmd_o,
  output logic viol_o,
  output logic [ccr_pkg::DATA_W-1:0] data_o,
  output logic [ccr_pkg::CMD_W-1:0] cmd_o
);
  import ccr_pkg::*;
  // ==========================================================================
  // Symbol queue
  // ==========================================================================
  // Each entry packs sync, command, violation, data and command code.
  logic [16:0] fifo[$];
  logic [16:0] sym;
  logic [3:0] cnt;

  task automatic push(input logic [16:0] s);
    fifo.push_back(s);
  endtask

  assign valid_o = 1'b1;
  assign {sync_o, is_cmd_o, viol_o, data_o, cmd_o} = sym;

  // ==========================================================================
  // Line timing
  // ==========================================================================
  // An empty queue keeps the line busy with syncs, so a word not ended by
  // the enable is closed by a sync once all receivers hold their byte.
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 4'h0;
      sym <= 17'h1_0000;
    end else begin
      cnt <= (cnt == BYTE_CNT_LAST) ? 4'h0 : cnt + 4'h1;
      if (cnt == BYTE_CNT_LAST) begin
        if (fifo.size() != 0) begin
          sym <= fifo.pop_front();
        end else begin
          sym <= 17'h1_0000;
        end
      end
    end
  end
endmodule
